// [core/i2cm_pkg.sv]
// Purpose: constants and types for the i2c master transfer engine
// Assumes: 125 MHz system clock, open-drain scl/sda with external pull-ups
// Notes:   one bit on the wire is four quarter periods of the serial clock
// Overview of operation
// - engine is bus master only and drives the serial clock at 100 kHz.
// - each transfer names its own target address, so many slaves share one bus.
// - write starts with START, 7-bit address, then direction bit low.
// - missing address acknowledge gives STOP and abandons the write without data.
// - acknowledged write sends count bytes from consecutive memory words from start index.
// - slave acknowledges each data byte; engine checks acknowledge after every byte.
// - write records acknowledge result: 1 received, 0 when sda stays high through the acknowledge slot.
// - acknowledged write ends without STOP, holding the bus for a following read.
// - read may follow write with no stop, opening with a new START.
// - read sends direction bit high and acknowledges every byte but the last.
// - after the last read byte engine withholds acknowledge, then sends STOP.
// - stop command has no parameters and places STOP on the bus only while the bus is held.
package i2cm_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_RATE_KHZ  = 100;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_RATE_KHZ;
  localparam int QTR_NS        = SCL_PERIOD_NS / 4;
  localparam int QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_WIN_CYC   = 2 * QTR_CYC;
  localparam int QW            = 9;
  localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYC - 1);
  localparam int AW = 12;
  localparam int DW = 16;
  localparam int CW = 8;
  localparam logic [1:0] OP_WRITE  = 2'h0;
  localparam logic [1:0] OP_READ   = 2'h1;
  localparam logic [1:0] OP_STOP   = 2'h2;
  localparam logic       DIR_WRITE = 1'b0;
  localparam logic       DIR_READ  = 1'b1;
  localparam logic [3:0] LAST_DATA = 4'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [1:0] PH_SET    = 2'h0;
  localparam logic [1:0] PH_RISE   = 2'h1;
  localparam logic [1:0] PH_HIGH   = 2'h2;
  localparam logic [1:0] PH_FALL   = 2'h3;
  localparam logic       ACK_OK_RST = 1'b0;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_SEND  = 6'h04,
    ST_RECV  = 6'h08,
    ST_FETCH = 6'h10,
    ST_STOP  = 6'h20
  } i2cm_state_type;
endpackage

// [core/i2cm_mem_if.sv]
`timescale 1ns/10ps
// Purpose: engine side port of the word data memory
// Assumes: read data registered one cycle after the address
// Notes:   engine writes win over host writes
interface i2cm_mem_if;
  logic                    we;
  logic [i2cm_pkg::AW-1:0] addr;
  logic [i2cm_pkg::DW-1:0] wdata;
  logic [i2cm_pkg::DW-1:0] rdata;
  modport eng (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// [core/i2cm_word_mem.sv]
`timescale 1ns/10ps
// Purpose: word data memory shared by the host and the transfer engine
// Assumes: single clock, registered reads on both ports
// Notes:   bytes live in the low eight bits of a word
module i2cm_word_mem (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // engine port
  i2cm_mem_if.mem                      eng,
  // host port
  input  wire logic                    host_we,
  input  wire logic [i2cm_pkg::AW-1:0] host_addr,
  input  wire logic [i2cm_pkg::DW-1:0] host_wdata,
  output logic      [i2cm_pkg::DW-1:0] host_rdata
);
  logic [i2cm_pkg::DW-1:0] word_data_memory [0:(1<<i2cm_pkg::AW)-1];

  always_ff @(posedge clk_sys) begin
    if (eng.we) begin
      word_data_memory[eng.addr] <= eng.wdata;
    end else if (host_we) begin
      word_data_memory[host_addr] <= host_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eng.rdata  <= '0;
      host_rdata <= '0;
    end else begin
      eng.rdata  <= word_data_memory[eng.addr];
      host_rdata <= word_data_memory[host_addr];
    end
  end
endmodule

// [core/i2cm_transfer.sv]
`timescale 1ns/10ps
// Purpose: i2c master engine for write, read and stop commands
// Assumes: one command at a time, taken while cmd_ready is high
// Notes:   an acknowledged write leaves scl low and the bus owned until stop or read
module i2cm_transfer (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // command port
  input  wire logic                    cmd_valid,
  input  wire logic [1:0]              cmd_op,
  input  wire logic [6:0]              cmd_target_address,
  input  wire logic [i2cm_pkg::AW-1:0] cmd_start,
  input  wire logic [i2cm_pkg::CW-1:0] cmd_count,
  output logic                         cmd_ready,
  output logic                         done,
  output logic                         ack_ok,
  output logic                         bus_held,
  // host access to word data memory
  input  wire logic                    host_we,
  input  wire logic [i2cm_pkg::AW-1:0] host_addr,
  input  wire logic [i2cm_pkg::DW-1:0] host_wdata,
  output logic      [i2cm_pkg::DW-1:0] host_rdata,
  // i2c pins, oe high pulls the line low
  input  wire logic                    scl_i,
  output logic                         scl_o,
  output logic                         scl_oe,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe
);
  i2cm_mem_if mem ();

  logic [1:0]                  rst_sync;
  logic                        rst_n;
  logic [1:0]                  scl_sync;
  logic [1:0]                  sda_sync;
  logic                        scl_s;
  logic                        sda_s;
  logic                        tick;
  i2cm_pkg::i2cm_state_type    state;
  i2cm_pkg::i2cm_state_type    next_state;
  logic [i2cm_pkg::QW-1:0]     qcnt;
  logic [i2cm_pkg::QW-1:0]     next_qcnt;
  logic [1:0]                  phase;
  logic [1:0]                  next_phase;
  logic [3:0]                  bitn;
  logic [3:0]                  next_bitn;
  logic [7:0]                  shreg;
  logic [7:0]                  next_shreg;
  logic [i2cm_pkg::AW-1:0]     idx;
  logic [i2cm_pkg::AW-1:0]     next_idx;
  logic [i2cm_pkg::CW-1:0]     left;
  logic [i2cm_pkg::CW-1:0]     next_left;
  logic                        rd;
  logic                        next_rd;
  logic                        addr_byte;
  logic                        next_addr_byte;
  logic                        ack_seen;
  logic                        next_ack_seen;
  logic                        fsub;
  logic                        next_fsub;
  logic                        we;
  logic                        next_we;
  logic [7:0]                  wdata;
  logic [7:0]                  next_wdata;
  logic                        next_ack_ok;
  logic                        next_held;
  logic                        next_ready;
  logic                        next_done;
  logic                        next_scl_oe;
  logic                        next_sda_oe;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end
  assign rst_n = rst_sync[1];
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];

  assign mem.addr  = idx;
  assign mem.we    = we;
  assign mem.wdata = {{(i2cm_pkg::DW-8){1'b0}}, wdata};

  i2cm_word_mem u_mem (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .eng        (mem.mem),
    .host_we    (host_we),
    .host_addr  (host_addr),
    .host_wdata (host_wdata),
    .host_rdata (host_rdata)
  );

  // quarter tick; a slave holding scl low stretches the rise phase
  assign tick = (qcnt == '0) && !(phase == i2cm_pkg::PH_RISE && !scl_s);

  always_comb begin
    next_state     = state;
    next_qcnt      = qcnt;
    next_phase     = phase;
    next_bitn      = bitn;
    next_shreg     = shreg;
    next_idx       = idx;
    next_left      = left;
    next_rd        = rd;
    next_addr_byte = addr_byte;
    next_ack_seen  = ack_seen;
    next_fsub      = 1'b0;
    next_we        = 1'b0;
    next_wdata     = wdata;
    next_ack_ok    = ack_ok;
    next_held      = bus_held;
    next_ready     = 1'b0;
    next_done      = 1'b0;
    next_scl_oe    = scl_oe;
    next_sda_oe    = sda_oe;
    if (state != i2cm_pkg::ST_IDLE && state != i2cm_pkg::ST_FETCH) begin
      if (tick) begin
        next_qcnt  = i2cm_pkg::QTR_LAST;
        next_phase = phase + 2'h1;
      end else if (qcnt != '0) begin
        next_qcnt = qcnt - 1'b1;
      end
      if (tick && phase == i2cm_pkg::PH_SET) next_scl_oe = 1'b0;
      // stop leaves scl released so the bus goes idle
      if (tick && phase == i2cm_pkg::PH_HIGH && state != i2cm_pkg::ST_STOP) next_scl_oe = 1'b1;
    end
    case (state)
      i2cm_pkg::ST_IDLE: begin
        next_ready = 1'b1;
        if (cmd_valid && cmd_ready) begin
          next_qcnt  = i2cm_pkg::QTR_LAST;
          next_phase = i2cm_pkg::PH_SET;
          next_rd    = (cmd_op == i2cm_pkg::OP_READ);
          next_idx   = cmd_start;
          next_left  = cmd_count;
          next_shreg = {cmd_target_address, (cmd_op == i2cm_pkg::OP_READ) ?
                        i2cm_pkg::DIR_READ : i2cm_pkg::DIR_WRITE};
          if (cmd_op == i2cm_pkg::OP_STOP) begin
            if (bus_held) begin
              next_ready  = 1'b0;
              next_state  = i2cm_pkg::ST_STOP;
              next_sda_oe = 1'b1;
            end else begin
              next_done = 1'b1;
            end
          end else if (cmd_op != 2'h3) begin
            next_ready  = 1'b0;
            next_state  = i2cm_pkg::ST_START;
            next_sda_oe = 1'b0;
          end
        end
      end
      i2cm_pkg::ST_START: begin
        if (tick && phase == i2cm_pkg::PH_RISE) next_sda_oe = 1'b1;
        if (tick && phase == i2cm_pkg::PH_FALL) begin
          next_state     = i2cm_pkg::ST_SEND;
          next_bitn      = 4'h0;
          next_addr_byte = 1'b1;
          next_sda_oe    = ~shreg[7];
        end
      end
      i2cm_pkg::ST_SEND: begin
        if (bitn == i2cm_pkg::ACK_SLOT && !sda_s &&
            (phase == i2cm_pkg::PH_RISE || phase == i2cm_pkg::PH_HIGH)) begin
          next_ack_seen = 1'b1;
        end
        if (tick && phase == i2cm_pkg::PH_FALL) begin
          if (bitn != i2cm_pkg::ACK_SLOT) begin
            next_bitn  = bitn + 4'h1;
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe = (bitn == i2cm_pkg::LAST_DATA) ? 1'b0 : ~shreg[6];
            if (bitn == i2cm_pkg::LAST_DATA) next_ack_seen = 1'b0;
          end else if (addr_byte) begin
            next_ack_ok = ack_seen;
            if (!ack_seen || (rd && left == '0)) begin
              next_state  = i2cm_pkg::ST_STOP;
              next_sda_oe = 1'b1;
            end else if (rd) begin
              next_state = i2cm_pkg::ST_RECV;
              next_bitn  = 4'h0;
            end else if (left == '0) begin
              next_state = i2cm_pkg::ST_IDLE;
              next_held  = 1'b1;
              next_done  = 1'b1;
            end else begin
              next_state = i2cm_pkg::ST_FETCH;
            end
          end else begin
            next_ack_ok = ack_seen;
            next_idx    = idx + 1'b1;
            next_left   = left - 1'b1;
            if (!ack_seen || left == 8'h01) begin
              next_state = i2cm_pkg::ST_IDLE;
              next_held  = 1'b1;
              next_done  = 1'b1;
            end else begin
              next_state = i2cm_pkg::ST_FETCH;
            end
          end
        end
      end
      i2cm_pkg::ST_FETCH: begin
        next_fsub = 1'b1;
        if (fsub) begin
          next_shreg     = mem.rdata[7:0];
          next_sda_oe    = ~mem.rdata[7];
          next_state     = i2cm_pkg::ST_SEND;
          next_bitn      = 4'h0;
          next_addr_byte = 1'b0;
          next_qcnt      = i2cm_pkg::QTR_LAST;
          next_phase     = i2cm_pkg::PH_SET;
        end
      end
      i2cm_pkg::ST_RECV: begin
        if (tick && phase == i2cm_pkg::PH_RISE && bitn != i2cm_pkg::ACK_SLOT) begin
          next_shreg = {shreg[6:0], sda_s};
        end
        if (tick && phase == i2cm_pkg::PH_FALL) begin
          if (bitn == i2cm_pkg::LAST_DATA) begin
            next_we     = 1'b1;
            next_wdata  = shreg;
            next_sda_oe = (left != 8'h01);
            next_bitn   = i2cm_pkg::ACK_SLOT;
          end else if (bitn == i2cm_pkg::ACK_SLOT) begin
            next_idx  = idx + 1'b1;
            next_left = left - 1'b1;
            next_bitn = 4'h0;
            next_sda_oe = (left == 8'h01);
            if (left == 8'h01) next_state = i2cm_pkg::ST_STOP;
          end else begin
            next_bitn = bitn + 4'h1;
          end
        end
      end
      i2cm_pkg::ST_STOP: begin
        if (tick && phase == i2cm_pkg::PH_RISE) next_sda_oe = 1'b0;
        if (tick && phase == i2cm_pkg::PH_FALL) begin
          next_state = i2cm_pkg::ST_IDLE;
          next_held  = 1'b0;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state  = i2cm_pkg::ST_IDLE;
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= i2cm_pkg::ST_IDLE;
      qcnt      <= i2cm_pkg::QTR_LAST;
      phase     <= i2cm_pkg::PH_SET;
      bitn      <= 4'h0;
      shreg     <= 8'h00;
      idx       <= '0;
      left      <= '0;
      rd        <= 1'b0;
      addr_byte <= 1'b0;
      ack_seen  <= 1'b0;
      fsub      <= 1'b0;
      we        <= 1'b0;
      wdata     <= 8'h00;
      ack_ok    <= i2cm_pkg::ACK_OK_RST;
      bus_held  <= 1'b0;
      cmd_ready <= 1'b0;
      done      <= 1'b0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
    end else begin
      state     <= next_state;
      qcnt      <= next_qcnt;
      phase     <= next_phase;
      bitn      <= next_bitn;
      shreg     <= next_shreg;
      idx       <= next_idx;
      left      <= next_left;
      rd        <= next_rd;
      addr_byte <= next_addr_byte;
      ack_seen  <= next_ack_seen;
      fsub      <= next_fsub;
      we        <= next_we;
      wdata     <= next_wdata;
      ack_ok    <= next_ack_ok;
      bus_held  <= next_held;
      cmd_ready <= next_ready;
      done      <= next_done;
      scl_oe    <= next_scl_oe;
      sda_oe    <= next_sda_oe;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_data_stable: assert property (
    (state == i2cm_pkg::ST_SEND || state == i2cm_pkg::ST_RECV) && !scl_oe && $past(!scl_oe)
    |-> $stable(sda_oe)) else $error("sda moved while scl high");
  chk_scl_high_len: assert property (
    state != i2cm_pkg::ST_IDLE && $fell(scl_oe) |-> !scl_oe [*8])
    else $error("scl high too short");
  chk_addr_nack_stop: assert property (
    state == i2cm_pkg::ST_SEND && addr_byte && bitn == i2cm_pkg::ACK_SLOT && tick &&
    phase == i2cm_pkg::PH_FALL && !ack_seen |=> state == i2cm_pkg::ST_STOP && sda_oe && !ack_ok)
    else $error("no stop after address nack");
  chk_write_dir: assert property (
    state == i2cm_pkg::ST_START && !rd && tick && phase == i2cm_pkg::PH_FALL
    |=> state == i2cm_pkg::ST_SEND && shreg[0] == i2cm_pkg::DIR_WRITE)
    else $error("write direction bit wrong");
  chk_read_dir: assert property (
    state == i2cm_pkg::ST_START && rd && tick && phase == i2cm_pkg::PH_FALL
    |=> shreg[0] == i2cm_pkg::DIR_READ) else $error("read direction bit wrong");
  chk_ack_record: assert property (
    state == i2cm_pkg::ST_SEND && !rd && bitn == i2cm_pkg::ACK_SLOT && tick &&
    phase == i2cm_pkg::PH_FALL |=> ack_ok == $past(ack_seen)) else $error("ack result lost");
  chk_write_holds: assert property (
    $past(state) == i2cm_pkg::ST_SEND && state == i2cm_pkg::ST_IDLE |-> bus_held && done)
    else $error("write released the bus");
  chk_last_nack: assert property (
    state == i2cm_pkg::ST_RECV && bitn == i2cm_pkg::ACK_SLOT && left == 8'h01 |-> !sda_oe)
    else $error("last read byte acknowledged");
  chk_read_ack: assert property (
    state == i2cm_pkg::ST_RECV && bitn == i2cm_pkg::ACK_SLOT && left > 8'h01 |-> sda_oe)
    else $error("read byte not acknowledged");
  chk_stop_cmd: assert property (
    state == i2cm_pkg::ST_IDLE && cmd_valid && cmd_ready && cmd_op == i2cm_pkg::OP_STOP &&
    bus_held |=> state == i2cm_pkg::ST_STOP ##1 sda_oe) else $error("stop command ignored");
  chk_stop_release: assert property (
    state == i2cm_pkg::ST_STOP && !scl_oe |=> !scl_oe)
    else $error("scl pulled low after stop");
  chk_fetch_word: assert property (
    state == i2cm_pkg::ST_FETCH && fsub |=> shreg == $past(mem.rdata[7:0]))
    else $error("fetched byte wrong");
endmodule

// [tb/i2cm_slave_model.sv]
`timescale 1ns/10ps
// Purpose: behavioural i2c slave on the far side of the transfer engine
// Assumes: open-drain wires with pull-ups resolved by the bench
// Notes:   answers one address; stretches scl low while slow is set
module i2cm_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h60
) (
  // resolved wire levels
  input  wire logic scl,
  input  wire logic sda,
  // far side drivers, high pulls the line low
  output logic      scl_pull,
  output logic      sda_pull,
  // behaviour
  input  wire logic slow
);
  logic [7:0] shift;
  logic [7:0] out_byte;
  logic [7:0] rx_bytes[$];
  logic [7:0] tx_bytes[$];
  logic       mack_log[$];
  logic       active;
  logic       addr_ph;
  logic       sel;
  logic       rd;
  logic       mack;
  logic       sending;
  int         cnt;
  int         stops;

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    active = 1'b0;
    stops = 0;
  end

  // start and stop seen while scl high
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    addr_ph = 1'b1;
    sending = 1'b0;
    cnt = 0;
    sda_pull = 1'b0;
  end

  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    stops = stops + 1;
    sda_pull = 1'b0;
  end

  always @(posedge scl) if (active) begin
    if (cnt < 8) begin
      shift = {shift[6:0], sda};
      cnt = cnt + 1;
    end else if (cnt == 8) begin
      cnt = 9;
      if (addr_ph) begin
        addr_ph = 1'b0;
        mack = 1'b1;
      end else begin
        mack = !sda;
        if (sel && rd) mack_log.push_back(mack);
      end
    end
  end

  always @(negedge scl) if (active) begin
    if (cnt == 8) begin
      sending = 1'b0;
      if (addr_ph) begin
        sel = (shift[7:1] == OWN_ADDR);
        rd = shift[0];
        sda_pull = sel;
      end else if (sel && !rd) begin
        rx_bytes.push_back(shift);
        sda_pull = 1'b1;
      end else begin
        sda_pull = 1'b0;
      end
    end else if (cnt == 9) begin
      cnt = 0;
      sda_pull = 1'b0;
      if (sel && rd && mack) begin
        out_byte = tx_bytes.pop_front();
        sending = 1'b1;
        sda_pull = !out_byte[7];
      end
    end else if (sending) begin
      sda_pull = !out_byte[3'(7 - cnt)];
    end
  end

  // slow answer: hold scl low past the master's low phase
  always @(negedge scl) if (active && slow) begin
    scl_pull = 1'b1;
    #8000 scl_pull = 1'b0;
  end
endmodule

// [tb/tb_i2cm_transfer.sv]
`timescale 1ns/10ps
// Purpose: self-checking bench for the i2c master transfer engine
// Assumes: one slave model at address 0x60 on pulled-up wires
// Notes:   a monitor pairs each done pulse with the oldest expected result
module tb_i2cm_transfer;
  typedef struct packed {
    logic chk_ack;
    logic ack;
    logic held;
  } i2cm_exp_type;

  logic                    clk_sys = 1'b0;
  logic                    resetn;
  logic                    cmd_valid;
  logic [1:0]              cmd_op;
  logic [6:0]              cmd_target_address;
  logic [i2cm_pkg::AW-1:0] cmd_start;
  logic [i2cm_pkg::CW-1:0] cmd_count;
  logic                    cmd_ready;
  logic                    done;
  logic                    ack_ok;
  logic                    bus_held;
  logic                    host_we;
  logic [i2cm_pkg::AW-1:0] host_addr;
  logic [i2cm_pkg::DW-1:0] host_wdata;
  logic [i2cm_pkg::DW-1:0] host_rdata;
  logic                    scl_oe;
  logic                    sda_oe;
  logic                    scl_o;
  logic                    sda_o;
  logic                    scl_pull;
  logic                    sda_pull;
  logic                    slow;
  logic                    scl_q = 1'b1;
  wire logic               scl_w;
  wire logic               sda_w;
  i2cm_exp_type            exp_q[$];
  i2cm_exp_type            cur;
  int                      miscompares = 0;
  int                      compares = 0;
  int                      per_cnt = 0;
  int                      per_exact = 0;
  int                      per_short = 0;

  assign scl_w = !(scl_oe === 1'b1 || scl_pull === 1'b1);
  assign sda_w = !(sda_oe === 1'b1 || sda_pull === 1'b1);

  always #4 clk_sys = ~clk_sys;

  i2cm_transfer i_i2cm_transfer (
    .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_target_address(cmd_target_address), .cmd_start(cmd_start),
    .cmd_count(cmd_count), .cmd_ready(cmd_ready), .done(done), .ack_ok(ack_ok),
    .bus_held(bus_held), .host_we(host_we), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );

  i2cm_slave_model i_i2cm_slave_model (
    .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull), .slow(slow)
  );

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic mem_write(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    host_we = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk_sys);
    host_we = 1'b0;
  endtask

  task automatic mem_read(input logic [11:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    host_addr = a;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    d = host_rdata;
  endtask

  task automatic run_cmd(input logic [1:0] op, input logic [6:0] adr, input logic [11:0] st,
                         input logic [7:0] n, input i2cm_exp_type e);
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      $display("Error cmd_ready expected 1 seen %b", cmd_ready);
      finish_test();
    end
    exp_q.push_back(e);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_target_address = adr;
    cmd_start = st;
    cmd_count = n;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (i = 0; i < 60000 && exp_q.size() != 0; i++) @(negedge clk_sys);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("Error done expected 1 seen 0");
      finish_test();
    end
  endtask

  // done monitor
  always @(negedge clk_sys) if (done === 1'b1) begin
    if (exp_q.size() == 0) begin
      miscompares++;
      $display("Error done expected 0 seen 1");
    end else begin
      cur = exp_q.pop_front();
      if (cur.chk_ack) check("ack_ok", 16'(cur.ack), 16'(ack_ok));
      check("bus_held", 16'(cur.held), 16'(bus_held));
    end
  end

  // scl rise-to-rise spacing
  always @(posedge clk_sys) begin
    scl_q <= scl_w;
    per_cnt <= (scl_w && !scl_q) ? 0 : per_cnt + 1;
    if (scl_w && !scl_q && per_cnt + 1 == 4 * i2cm_pkg::QTR_CYC) per_exact <= per_exact + 1;
    if (scl_w && !scl_q && per_cnt + 1 < 4 * i2cm_pkg::QTR_CYC) per_short <= per_short + 1;
  end

  initial begin
    logic [15:0] w;
    logic [15:0] rw;
    logic [7:0]  b0;
    logic [7:0]  b1;
    int          s0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_target_address = 7'h00;
    cmd_start = 12'h000;
    cmd_count = 8'h00;
    host_we = 1'b0;
    host_addr = 12'h000;
    host_wdata = 16'h0000;
    slow = 1'b0;
    void'($urandom(32'h1ea84d00));
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    // write one byte, bus left held
    w = 16'($urandom);
    mem_write(12'h005, w);
    run_cmd(i2cm_pkg::OP_WRITE, 7'h60, 12'h005, 8'h01, 3'b111);
    check("rx count", 16'h0001, 16'(i2cm_i2cm_rx_size()));
    check("rx byte", {8'h00, w[7:0]}, {8'h00, i_i2cm_slave_model.rx_bytes[0]});
    check("scl held", 16'h0000, 16'(scl_w));
    $display("test write done");
    // stop command
    s0 = i_i2cm_slave_model.stops;
    run_cmd(i2cm_pkg::OP_STOP, 7'h00, 12'h000, 8'h00, 3'b000);
    check("stop seen", 16'(s0 + 1), 16'(i_i2cm_slave_model.stops));
    check("lines idle", 16'h0003, {14'h0000, scl_w, sda_w});
    $display("test stop done");
    // absent slave
    s0 = i_i2cm_slave_model.stops;
    run_cmd(i2cm_pkg::OP_WRITE, 7'h33, 12'h006, 8'h02, 3'b100);
    check("rx count", 16'h0001, 16'(i2cm_i2cm_rx_size()));
    check("stop seen", 16'(s0 + 1), 16'(i_i2cm_slave_model.stops));
    $display("test absent done");
    // address-only write (count 0) then read with repeated start, slave stretching
    run_cmd(i2cm_pkg::OP_WRITE, 7'h60, 12'h000, 8'h00, 3'b111);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    i_i2cm_slave_model.tx_bytes.push_back(b0);
    i_i2cm_slave_model.tx_bytes.push_back(b1);
    s0 = i_i2cm_slave_model.stops;
    slow = 1'b1;
    run_cmd(i2cm_pkg::OP_READ, 7'h60, 12'h014, 8'h02, 3'b110);
    slow = 1'b0;
    check("master ack", 16'h0001, 16'(i_i2cm_slave_model.mack_log[0]));
    check("master nack", 16'h0000, 16'(i_i2cm_slave_model.mack_log[1]));
    check("stop seen", 16'(s0 + 1), 16'(i_i2cm_slave_model.stops));
    mem_read(12'h014, rw);
    check("word 20", {8'h00, b0}, rw);
    mem_read(12'h015, rw);
    check("word 21", {8'h00, b1}, rw);
    $display("test read done");
    // stop with the bus already released: done only, no wire activity
    s0 = i_i2cm_slave_model.stops;
    run_cmd(i2cm_pkg::OP_STOP, 7'h00, 12'h000, 8'h00, 3'b000);
    check("idle stop", 16'(s0), 16'(i_i2cm_slave_model.stops));
    check("pin levels", 16'h0000, {14'h0000, scl_o, sda_o});
    $display("test idle stop done");
    check("scl period seen", 16'h0001, 16'(per_exact > 0));
    check("scl period short", 16'h0000, 16'(per_short));
    finish_test();
  end

  function automatic int i2cm_i2cm_rx_size();
    return i_i2cm_slave_model.rx_bytes.size();
  endfunction
endmodule
